// *** logic/subb_swap_consts.vh ***
// Constants shared by the subtract-with-borrow and nibble-exchange datapath
`ifndef SUBB_SWAP_CONSTS_VH
`define SUBB_SWAP_CONSTS_VH

// ----------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------
`define OPC_MSB 15
`define OPC_LSB 10
`define OPC_SUB_BORROW 6'h16
`define OPC_NIBBLE_SWAP 6'h0e
`define INSTR_DEST_BIT 9
`define INSTR_BANK_BIT 8
`define INSTR_F_MSB 7
`define INSTR_F_LSB 0

// ----------------------------------------------------------------
// Data memory addressing
// ----------------------------------------------------------------
`define ACCESS_LOW_LIMIT 8'h80
`define INDEXED_LIMIT 8'h5f
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hf

// ----------------------------------------------------------------
// Register port offsets
// ----------------------------------------------------------------
`define REG_WORK 4'h0
`define REG_STATUS 4'h1
`define REG_BANK 4'h2
`define REG_INDEX_LO 4'h3
`define REG_INDEX_HI 4'h4
`define REG_CONTROL 4'h5
`define REG_MEM_PTR_LO 4'h6
`define REG_MEM_PTR_HI 4'h7
`define REG_MEM_DATA 4'h8
`define REG_STATE 4'h9

// ----------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_OV 3
`define ST_N 4
`define STATUS_RESET 5'h00
`define WORK_RESET 8'h00
`define BANK_RESET 4'h0
`define INDEX_RESET 12'h000
`define CONTROL_EXT_BIT 0

`endif

// *** logic/dual_port_ram.v ***
// Byte-wide data memory with two ports and registered read data
`timescale 1ns/1ns
`default_nettype none

module dual_port_ram #(
	parameter AW = 12,
	parameter DW = 8
) (
	// Clock
	input wire i_clk,
	// Core port
	input wire [AW-1:0] i_a_addr,
	input wire i_a_we,
	input wire [DW-1:0] i_a_wdata,
	output reg [DW-1:0] o_a_q,
	// Software port
	input wire [AW-1:0] i_b_addr,
	input wire i_b_we,
	input wire [DW-1:0] i_b_wdata,
	output reg [DW-1:0] o_b_q
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Core write is placed last so it wins a same-address collision
	always @(posedge i_clk)
	begin
		if (i_b_we)
			mem[i_b_addr] <= i_b_wdata;
		if (i_a_we)
			mem[i_a_addr] <= i_a_wdata;
		o_a_q <= mem[i_a_addr];
		o_b_q <= mem[i_b_addr];
	end

endmodule

`default_nettype wire

// *** logic/subb_swap_alu.v ***
// Combinational arithmetic for borrow subtraction and nibble exchange
`timescale 1ns/1ns
`default_nettype none
`include "subb_swap_consts.vh"

module subb_swap_alu (
	// Operation select
	input wire i_is_swap,
	// Operands
	input wire [7:0] i_f,
	input wire [7:0] i_w,
	input wire i_carry,
	// Results
	output reg [7:0] o_result,
	output reg [4:0] o_flags,
	output reg o_flags_we
);

	reg [8:0] sum;
	reg [4:0] low;

	always @*
	begin
		sum = 9'h000;
		low = 5'h00;
		o_result = 8'h00;
		o_flags = 5'h00;
		o_flags_we = 1'b0;
		if (i_is_swap)
		begin
			o_result = {i_f[3:0], i_f[7:4]};
			o_flags_we = 1'b0;
		end
		else
		begin
			// Minus w minus borrow equals plus inverted w plus carry
			sum = {1'b0, i_f} + {1'b0, ~i_w} + {8'h00, i_carry};
			low = {1'b0, i_f[3:0]} + {1'b0, ~i_w[3:0]} + {4'h0, i_carry};
			o_result = sum[7:0];
			o_flags[`ST_C] = sum[8];
			o_flags[`ST_DC] = low[4];
			o_flags[`ST_Z] = (sum[7:0] == 8'h00);
			o_flags[`ST_OV] = (i_f[7] != i_w[7]) && (sum[7] != i_f[7]);
			o_flags[`ST_N] = sum[7];
			o_flags_we = 1'b1;
		end
	end

endmodule

`default_nettype wire

// *** logic/subb_swap_core.v ***
// Four-phase execution unit for borrow subtraction and nibble exchange
`timescale 1ns/1ns
`default_nettype none
`include "subb_swap_consts.vh"

module subb_swap_core #(
	parameter AW = 12
) (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Instruction issue
	input wire i_instr_valid,
	input wire [15:0] i_instr,
	output reg o_ready,
	output reg o_done,
	output reg o_illegal,
	// Register port
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	// Phase observation
	output reg [2:0] o_phase
);

	// ----------------------------------------------------------------
	// Phase encoding
	// ----------------------------------------------------------------
	localparam PH_IDLE = 3'h0;
	localparam PH_DECODE = 3'h1;
	localparam PH_READ = 3'h2;
	localparam PH_COMPUTE = 3'h3;
	localparam PH_WRITE = 3'h4;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [15:0] instr;
	reg [AW-1:0] addr_eff;
	reg legal;
	reg is_swap;
	reg dest_file;
	reg [7:0] result;
	reg [4:0] alu_flags;
	reg flags_we;
	reg [7:0] work;
	reg [4:0] status;
	reg [3:0] bank_pointer_register;
	reg [11:0] index_base;
	reg ext_enable;
	reg [AW-1:0] mem_ptr;
	reg [2:0] next_phase;
	reg [AW-1:0] next_addr;
	reg [5:0] next_opc;
	reg next_legal;

	wire [7:0] f_operand;
	wire bank_sel;
	wire [7:0] mem_a_q;
	wire [7:0] mem_b_q;
	wire [7:0] alu_result;
	wire [4:0] alu_flag_bits;
	wire alu_flags_we;
	wire take;
	wire core_mem_we;
	wire sw_mem_we;
	wire [11:0] indexed_addr;
	wire [11:0] general_addr;

	assign take = i_instr_valid && o_ready;
	assign f_operand = instr[`INSTR_F_MSB:`INSTR_F_LSB];
	assign bank_sel = instr[`INSTR_BANK_BIT];
	assign indexed_addr = index_base + {4'h0, f_operand};
	assign general_addr = {bank_pointer_register, f_operand};
	assign core_mem_we = (o_phase == PH_WRITE) && legal && dest_file;
	assign sw_mem_we = i_wr && (i_addr == `REG_MEM_DATA);

	// ----------------------------------------------------------------
	// Phase sequencing
	// ----------------------------------------------------------------
	always @*
	begin
		next_phase = PH_IDLE;
		case (o_phase)
			PH_IDLE:
				next_phase = take ? PH_DECODE : PH_IDLE;
			PH_DECODE:
				next_phase = PH_READ;
			PH_READ:
				next_phase = PH_COMPUTE;
			PH_COMPUTE:
				next_phase = PH_WRITE;
			PH_WRITE:
				next_phase = take ? PH_DECODE : PH_IDLE;
			default:
				next_phase = PH_IDLE;
		endcase
	end

	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_phase <= PH_IDLE;
			o_ready <= 1'b1;
			instr <= 16'h0000;
		end
		else
		begin
			o_phase <= next_phase;
			o_ready <= (next_phase == PH_IDLE) || (next_phase == PH_WRITE);
			if (take)
				instr <= i_instr;
		end
	end

	// ----------------------------------------------------------------
	// Decode and operand address
	// ----------------------------------------------------------------
	always @*
	begin
		next_opc = instr[`OPC_MSB:`OPC_LSB];
		next_legal = (next_opc == `OPC_SUB_BORROW) ||
			(next_opc == `OPC_NIBBLE_SWAP);
		next_addr = general_addr[AW-1:0];
		if (!bank_sel)
		begin
			if (ext_enable && (f_operand <= `INDEXED_LIMIT))
				next_addr = indexed_addr[AW-1:0];
			else if (f_operand < `ACCESS_LOW_LIMIT)
				next_addr = {`ACCESS_LOW_BANK, f_operand};
			else
				next_addr = {`ACCESS_HIGH_BANK, f_operand};
		end
	end

	// Address is frozen in decode so the read and the write hit one byte
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			addr_eff <= {AW{1'b0}};
			legal <= 1'b0;
			is_swap <= 1'b0;
			dest_file <= 1'b0;
		end
		else if (o_phase == PH_DECODE)
		begin
			addr_eff <= next_addr;
			legal <= next_legal;
			is_swap <= (next_opc == `OPC_NIBBLE_SWAP);
			dest_file <= instr[`INSTR_DEST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Data memory and arithmetic
	// ----------------------------------------------------------------
	dual_port_ram #(
		.AW(AW),
		.DW(8)
	) u_ram (
		.i_clk(i_clk),
		.i_a_addr(addr_eff),
		.i_a_we(core_mem_we),
		.i_a_wdata(result),
		.o_a_q(mem_a_q),
		.i_b_addr(mem_ptr),
		.i_b_we(sw_mem_we),
		.i_b_wdata(i_wdata),
		.o_b_q(mem_b_q)
	);

	subb_swap_alu u_alu (
		.i_is_swap(is_swap),
		.i_f(mem_a_q),
		.i_w(work),
		.i_carry(status[`ST_C]),
		.o_result(alu_result),
		.o_flags(alu_flag_bits),
		.o_flags_we(alu_flags_we)
	);

	// File byte arrives from the read phase, result captured in compute
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			result <= 8'h00;
			alu_flags <= 5'h00;
			flags_we <= 1'b0;
		end
		else if (o_phase == PH_COMPUTE)
		begin
			result <= alu_result;
			alu_flags <= alu_flag_bits;
			flags_we <= alu_flags_we && legal;
		end
	end

	// ----------------------------------------------------------------
	// Work, status and software registers
	// ----------------------------------------------------------------
	// Hardware update in the write phase wins over a software write
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			work <= `WORK_RESET;
			status <= `STATUS_RESET;
			bank_pointer_register <= `BANK_RESET;
			index_base <= `INDEX_RESET;
			ext_enable <= 1'b0;
			mem_ptr <= {AW{1'b0}};
		end
		else
		begin
			if (o_phase == PH_WRITE && legal && !dest_file)
				work <= result;
			else if (i_wr && i_addr == `REG_WORK)
				work <= i_wdata;
			if (o_phase == PH_WRITE && flags_we)
				status <= alu_flags;
			else if (i_wr && i_addr == `REG_STATUS)
				status <= i_wdata[4:0];
			if (i_wr)
			begin
				case (i_addr)
					`REG_BANK:
						bank_pointer_register <= i_wdata[3:0];
					`REG_INDEX_LO:
						index_base[7:0] <= i_wdata;
					`REG_INDEX_HI:
						index_base[11:8] <= i_wdata[3:0];
					`REG_CONTROL:
						ext_enable <= i_wdata[`CONTROL_EXT_BIT];
					`REG_MEM_PTR_LO:
						mem_ptr[7:0] <= i_wdata;
					`REG_MEM_PTR_HI:
						mem_ptr[AW-1:8] <= i_wdata[AW-9:0];
					default:
						mem_ptr <= mem_ptr;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Completion and read-back
	// ----------------------------------------------------------------
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_done <= 1'b0;
			o_illegal <= 1'b0;
		end
		else
		begin
			o_done <= (o_phase == PH_WRITE);
			o_illegal <= (o_phase == PH_WRITE) && !legal;
		end
	end

	// Memory data is prefetched at the pointer, so it lags a pointer write
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_rdata <= 8'h00;
		else if (i_rd)
		begin
			case (i_addr)
				`REG_WORK:
					o_rdata <= work;
				`REG_STATUS:
					o_rdata <= {3'h0, status};
				`REG_BANK:
					o_rdata <= {4'h0, bank_pointer_register};
				`REG_INDEX_LO:
					o_rdata <= index_base[7:0];
				`REG_INDEX_HI:
					o_rdata <= {4'h0, index_base[11:8]};
				`REG_CONTROL:
					o_rdata <= {7'h00, ext_enable};
				`REG_MEM_PTR_LO:
					o_rdata <= mem_ptr[7:0];
				`REG_MEM_PTR_HI:
					o_rdata <= {{(16-AW){1'b0}}, mem_ptr[AW-1:8]};
				`REG_MEM_DATA:
					o_rdata <= mem_b_q;
				`REG_STATE:
					o_rdata <= {4'h0, o_ready, o_phase};
				default:
					o_rdata <= 8'h00;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** dv/subb_swap_core_asserts.sv ***
// Port timing checker for the four-phase execution unit
`timescale 1ns/1ns
`default_nettype none

module subb_swap_core_asserts (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Issue and status
	input wire logic i_instr_valid,
	input wire logic o_ready,
	input wire logic o_done,
	input wire logic o_illegal,
	input wire logic [2:0] o_phase,
	// Register port
	input wire logic i_rd,
	input wire logic [7:0] o_rdata
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	wire logic take;
	assign take = i_instr_valid && o_ready;

	a_done_five: assert property (take |-> ##5 o_done)
		else $error("done not five cycles after issue");
	a_phase_walk: assert property (take |=> o_phase == 3'h1 ##1
		o_phase == 3'h2 ##1 o_phase == 3'h3 ##1 o_phase == 3'h4)
		else $error("phase order broken");
	a_busy_refuse: assert property (
		o_phase inside {3'h1, 3'h2, 3'h3} |-> !o_ready)
		else $error("ready during busy phase");
	a_idle_ready: assert property (o_phase == 3'h0 |-> o_ready)
		else $error("not ready while idle");
	a_done_cause: assert property (o_done |-> $past(o_phase) == 3'h4)
		else $error("done without write phase");
	a_idle_return: assert property (
		o_phase == 3'h4 && !take |=> o_phase == 3'h0 && o_done)
		else $error("no return to idle");
	a_illegal_done: assert property (o_illegal |-> o_done)
		else $error("illegal without done");
	a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data moved without read");
endmodule

`default_nettype wire

// *** dv/subtract_borrow_nibble_swap_test.sv ***
// Self-checking bench for the borrow subtraction and nibble exchange unit
`timescale 1ns/1ns
`default_nettype none
`include "subb_swap_consts.vh"

module subtract_borrow_nibble_swap_test;
	logic i_clk;
	logic i_rst;
	logic i_instr_valid;
	logic [15:0] i_instr;
	logic i_wr;
	logic i_rd;
	logic [3:0] i_addr;
	logic [7:0] i_wdata;
	wire logic o_ready;
	wire logic o_done;
	wire logic o_illegal;
	wire logic [7:0] o_rdata;
	wire logic [2:0] o_phase;
	int miscompares = 0;
	int checks = 0;
	int k;
	logic [31:0] seed = 32'h0000001f;
	logic [31:0] r;
	logic [31:0] r2;
	logic [7:0] f, w, v, res, ew, em;
	logic [4:0] st, es;
	logic [3:0] bank;
	logic [11:0] idx, ma;
	logic [8:0] sum;
	logic [5:0] opc;
	logic d, a, ext, dc, ov;
	logic [1:0] op;

	subb_swap_core dut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_instr_valid(i_instr_valid),
		.i_instr(i_instr),
		.o_ready(o_ready),
		.o_done(o_done),
		.o_illegal(o_illegal),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.o_phase(o_phase)
	);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= dt;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] ad, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask

	task exec(input logic [15:0] ins, input logic ill);
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_instr <= ins;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		for (k = 0; k < 9 && o_done !== 1'b1; k++)
			@(posedge i_clk) #1;
		// Done shows four edges past the taking edge
		chk(k[7:0], 8'h04);
		chk({7'h0, o_illegal}, {7'h0, ill});
	endtask

	task report_and_stop;
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	initial
	begin
		repeat (20000) @(posedge i_clk);
		miscompares++;
		report_and_stop;
	end

	initial
	begin
		i_rst = 1'b1;
		i_instr_valid = 1'b0;
		i_instr = 16'h0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(4'h1, 8'h00);
		repeat (60)
		begin
			r = xs();
			r2 = xs();
			{f, d, a, ext, op, bank, w} = r[24:0];
			{idx, v, st} = r2[24:0];
			// Operand address as the bank and index rules place it
			if (a)
				ma = {bank, f};
			else if (ext && f <= 8'h5f)
				ma = idx + {4'h0, f};
			else
				ma = {(f < 8'h80) ? 4'h0 : 4'hf, f};
			wr(4'h6, ma[7:0]);
			wr(4'h7, {4'h0, ma[11:8]});
			wr(4'h8, v);
			wr(4'h0, w);
			wr(4'h1, {3'h0, st});
			wr(4'h2, {4'h0, bank});
			wr(4'h3, idx[7:0]);
			wr(4'h4, {4'h0, idx[11:8]});
			wr(4'h5, {7'h0, ext});
			opc = (op == 2'h0) ? 6'h3f :
				(op == 2'h1) ? `OPC_NIBBLE_SWAP : `OPC_SUB_BORROW;
			sum = {1'b0, v} + {1'b0, ~w} + {8'h00, st[0]};
			dc = ({1'b0, v[3:0]} + {1'b0, ~w[3:0]} + {4'h0, st[0]}) > 5'h0f;
			res = (op == 2'h1) ? {v[3:0], v[7:4]} : sum[7:0];
			ov = (v[7] != w[7]) && (res[7] != v[7]);
			es = (op[1]) ? {res[7], ov, res == 8'h00, dc, sum[8]} : st;
			ew = (op != 2'h0 && !d) ? res : w;
			em = (op != 2'h0 && d) ? res : v;
			exec({opc, d, a, f}, op == 2'h0);
			rd(4'h0, ew);
			rd(4'h1, {3'h0, es});
			rd(4'h8, em);
		end
		// Second issue offered in the write phase of the first
		wr(4'h6, 8'h10);
		wr(4'h7, 8'h00);
		wr(4'h8, 8'h53);
		wr(4'h5, 8'h00);
		@(posedge i_clk);
		i_instr_valid <= 1'b1;
		i_instr <= {`OPC_NIBBLE_SWAP, 2'b10, 8'h10};
		repeat (5) @(posedge i_clk);
		i_instr_valid <= 1'b0;
		repeat (10) @(posedge i_clk);
		rd(4'h8, 8'h53);
		rd(4'ha, 8'h00);
		rd(4'h9, 8'h08);
		// Mid-run reset clears the work register and the phase
		@(posedge i_clk);
		i_rst <= 1'b1;
		@(posedge i_clk);
		i_rst <= 1'b0;
		rd(4'h0, 8'h00);
		rd(4'h9, 8'h08);
		report_and_stop;
	end
endmodule

bind subb_swap_core subb_swap_core_asserts chk_i (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_instr_valid(i_instr_valid),
	.o_ready(o_ready),
	.o_done(o_done),
	.o_illegal(o_illegal),
	.o_phase(o_phase),
	.i_rd(i_rd),
	.o_rdata(o_rdata)
);

`default_nettype wire
